//--- rtl/pic_pkg.sv
// constants shared by the pixel input capture front end
// assumes one system clock for configuration and one pixel link clock
package pic_pkg;

  // ---------------------------------------------------------------
  // pixel bus
  // ---------------------------------------------------------------
  localparam int PIX_W = 24;
  localparam int HALF_W = 12;
  localparam int CTL_W = 3;
  localparam int CTL_PIN_W = 2;

  // ---------------------------------------------------------------
  // skew trim
  // ---------------------------------------------------------------
  localparam int TRIM_W = 3;
  localparam logic [TRIM_W-1:0] TRIM_DEFAULT = 3'h0;
  // delay of one trim step in ps; the delay line itself sits outside
  localparam int TRIM_STEP_PS = 100;

  // ---------------------------------------------------------------
  // strap vector layout (after the pin synchroniser)
  // ---------------------------------------------------------------
  localparam int STRAP_BW = 0;
  localparam int STRAP_STYLE = 1;
  localparam int STRAP_EDGE = 2;
  localparam int STRAP_LOWSW = 3;
  localparam int STRAP_PD = 4;
  localparam int STRAP_SKEW_TRIM_ENABLE = 5;
  localparam int STRAP_SEN = 6;
  localparam int STRAP_MF = 7;
  localparam int STRAP_W = 10;

  // ---------------------------------------------------------------
  // configuration passed to the link domain
  // ---------------------------------------------------------------
  localparam int LCFG_DUAL = 0;
  localparam int LCFG_RISE = 1;
  localparam int LCFG_CTLP = 2;
  localparam int LCFG_W = 3;

endpackage

//--- rtl/pic_sync3.sv
// three-stage level synchroniser with agreement filter
// assumes i_d is asynchronous to i_clk and changes slowly
`timescale 1ns/1ps
module pic_sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // a bit is taken only once the second and third stage agree
  assign q_d = (s2_q == s3_q) ? s3_q : q_q;
  assign o_q = q_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q <= '0;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

endmodule

//--- rtl/pic_capture.sv
// pixel input capture and strap configuration front end
// assumes straps are quasi-static and the pixel clock comes from the
// differential receiver output (crossing point) or the single-ended pin
`timescale 1ns/1ps
module pic_capture (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_input_pixel_clock,
  input wire logic [23:0] i_data,
  input wire logic i_video_active_qualifier,
  input wire logic i_hsync,
  input wire logic i_vsync,
  input wire logic i_blanking_control_bit3,
  input wire logic i_bus_width_select,
  input wire logic i_clock_style_select,
  input wire logic i_edge_select,
  input wire logic i_low_swing_ref,
  input wire logic i_power_down,
  input wire logic i_skew_trim_enable,
  input wire logic [2:0] i_mf_pins,
  input wire logic i_serial_port_enable,
  input wire logic i_ser_dual_edge,
  input wire logic i_ser_rising_primary,
  input wire logic i_ser_diff_clock,
  input wire logic i_ser_skew_en,
  input wire logic [2:0] i_ser_skew_code,
  input wire logic i_ser_power_down,
  input wire logic i_ser_scl_hold,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_dual_edge,
  output logic o_rising_primary,
  output logic o_diff_clock,
  output logic o_style_conflict,
  output logic o_skew_en,
  output logic [2:0] o_skew_code,
  output logic o_power_down,
  output logic [23:0] o_pix_data,
  output logic o_pix_valid,
  output logic o_enc_hsync,
  output logic o_enc_vsync,
  output logic [2:0] o_enc_ctl
);

  // ---------------------------------------------------------------
  // strap synchronisation (system clock)
  // ---------------------------------------------------------------
  logic [pic_pkg::STRAP_W-1:0] strap_raw;
  logic [pic_pkg::STRAP_W-1:0] strap_s;

  assign strap_raw = {i_mf_pins, i_serial_port_enable, i_skew_trim_enable, i_power_down,
                      i_low_swing_ref, i_edge_select, i_clock_style_select,
                      i_bus_width_select};

  pic_sync3 #(.W(pic_pkg::STRAP_W)) u_strap_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(strap_raw),
    .o_q(strap_s)
  );

  // ---------------------------------------------------------------
  // configuration select
  // ---------------------------------------------------------------
  logic ser_en;
  logic [pic_pkg::TRIM_W-1:0] strap_code;
  logic dual_d, rise_d, diff_req, diff_d, conflict_d, sk_en_d, pd_d, ctlp_d, scl_oe_d;
  logic [pic_pkg::TRIM_W-1:0] code_d;
  logic dual_q, rise_q, diff_q, conflict_q, sk_en_q, pd_q, ctlp_q, scl_oe_q;
  logic [pic_pkg::TRIM_W-1:0] code_q;

  assign ser_en = strap_s[pic_pkg::STRAP_SEN];
  assign strap_code = strap_s[pic_pkg::STRAP_MF +: pic_pkg::TRIM_W];
  assign dual_d = ser_en ? i_ser_dual_edge : ~strap_s[pic_pkg::STRAP_BW];
  assign rise_d = ser_en ? i_ser_rising_primary : strap_s[pic_pkg::STRAP_EDGE];
  assign diff_req = ser_en ? i_ser_diff_clock : strap_s[pic_pkg::STRAP_STYLE];
  // a full-swing request for differential clocking falls back to single-ended
  assign diff_d = diff_req & strap_s[pic_pkg::STRAP_LOWSW];
  assign conflict_d = diff_req & ~strap_s[pic_pkg::STRAP_LOWSW];
  assign sk_en_d = ser_en ? i_ser_skew_en : strap_s[pic_pkg::STRAP_SKEW_TRIM_ENABLE];
  assign code_d = !sk_en_d ? pic_pkg::TRIM_DEFAULT :
                  (ser_en ? i_ser_skew_code : strap_code);
  assign pd_d = ser_en ? i_ser_power_down : strap_s[pic_pkg::STRAP_PD];
  assign ctlp_d = ~ser_en & ~strap_s[pic_pkg::STRAP_SKEW_TRIM_ENABLE];
  // width pin only pulls low, and only while serial mode owns it
  assign scl_oe_d = ser_en & i_ser_scl_hold;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dual_q <= 1'b0;
      rise_q <= 1'b0;
      diff_q <= 1'b0;
      conflict_q <= 1'b0;
      sk_en_q <= 1'b0;
      code_q <= pic_pkg::TRIM_DEFAULT;
      pd_q <= 1'b0;
      ctlp_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      dual_q <= dual_d;
      rise_q <= rise_d;
      diff_q <= diff_d;
      conflict_q <= conflict_d;
      sk_en_q <= sk_en_d;
      code_q <= code_d;
      pd_q <= pd_d;
      ctlp_q <= ctlp_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  assign o_scl_o = 1'b0;
  assign o_scl_oe = scl_oe_q;
  assign o_dual_edge = dual_q;
  assign o_rising_primary = rise_q;
  assign o_diff_clock = diff_q;
  assign o_style_conflict = conflict_q;
  assign o_skew_en = sk_en_q;
  assign o_skew_code = code_q;
  assign o_power_down = pd_q;

  // ---------------------------------------------------------------
  // link domain reset and configuration crossing
  // ---------------------------------------------------------------
  logic lrst1_q, lrst2_q, link_rstn;
  logic [pic_pkg::LCFG_W-1:0] lcfg;
  logic l_dual, l_rise, l_ctlp;

  always_ff @(posedge i_input_pixel_clock) begin
    lrst1_q <= i_rstn;
    lrst2_q <= lrst1_q;
  end
  assign link_rstn = lrst2_q;

  // bits are taken as one word once two stages agree; a mode change may lag a few pixels, which is
  // accepted since the settings are static while video runs
  pic_sync3 #(.W(pic_pkg::LCFG_W)) u_cfg_sync (
    .i_clk(i_input_pixel_clock),
    .i_rstn(link_rstn),
    .i_d({ctlp_q, rise_q, dual_q}),
    .o_q(lcfg)
  );
  assign l_dual = lcfg[pic_pkg::LCFG_DUAL];
  assign l_rise = lcfg[pic_pkg::LCFG_RISE];
  assign l_ctlp = lcfg[pic_pkg::LCFG_CTLP];

  // ---------------------------------------------------------------
  // pin capture on both edges of the reference clock
  // ---------------------------------------------------------------
  logic [pic_pkg::PIX_W-1:0] rdat_q, fdat_q;
  logic rde_q, fde_q, rhs_q, fhs_q, rvs_q, fvs_q, rc3_q, fc3_q;
  logic [pic_pkg::CTL_PIN_W-1:0] rmf_q, fmf_q;

  // the clock port is the receiver's crossing output
  always_ff @(posedge i_input_pixel_clock) begin
    rdat_q <= i_data;
    rde_q <= i_video_active_qualifier;
    rhs_q <= i_hsync;
    rvs_q <= i_vsync;
    rc3_q <= i_blanking_control_bit3;
    rmf_q <= i_mf_pins[pic_pkg::CTL_PIN_W-1:0];
  end

  // falling edge latch serves dual-edge and falling primary
  always_ff @(negedge i_input_pixel_clock) begin
    fdat_q <= i_data;
    fde_q <= i_video_active_qualifier;
    fhs_q <= i_hsync;
    fvs_q <= i_vsync;
    fc3_q <= i_blanking_control_bit3;
    fmf_q <= i_mf_pins[pic_pkg::CTL_PIN_W-1:0];
  end

  // ---------------------------------------------------------------
  // primary / secondary selection and pixel assembly
  // ---------------------------------------------------------------
  logic [pic_pkg::PIX_W-1:0] prim_dat, pix_w;
  logic [pic_pkg::HALF_W-1:0] sec_lo;
  logic prim_de, prim_hs, prim_vs, prim_c3;
  logic [pic_pkg::CTL_PIN_W-1:0] prim_mf, ctl_lo;

  assign prim_dat = l_rise ? rdat_q : fdat_q;
  assign prim_de = l_rise ? rde_q : fde_q;
  assign prim_hs = l_rise ? rhs_q : fhs_q;
  assign prim_vs = l_rise ? rvs_q : fvs_q;
  assign prim_c3 = l_rise ? rc3_q : fc3_q;
  assign prim_mf = l_rise ? rmf_q : fmf_q;
  // the secondary half follows the primary: falling latch, or live pins
  assign sec_lo = l_rise ? fdat_q[pic_pkg::HALF_W-1:0] : i_data[pic_pkg::HALF_W-1:0];
  assign pix_w = l_dual ? {sec_lo, prim_dat[pic_pkg::HALF_W-1:0]} : prim_dat;
  assign ctl_lo = l_ctlp ? prim_mf : '0;

  always_ff @(posedge i_input_pixel_clock) begin
    if (!link_rstn) begin
      o_pix_data <= '0;
      o_pix_valid <= 1'b0;
      o_enc_hsync <= 1'b0;
      o_enc_vsync <= 1'b0;
      o_enc_ctl <= '0;
    end else begin
      o_pix_data <= prim_de ? pix_w : '0;
      o_pix_valid <= prim_de;
      o_enc_hsync <= prim_hs;
      o_enc_vsync <= prim_vs;
      o_enc_ctl <= {prim_c3, ctl_lo};
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_diff_low_swing: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !strap_s[pic_pkg::STRAP_LOWSW] |=> !o_diff_clock)
    else $error("differential clock chosen with full-swing levels");
  a_width_strap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ser_en |=> o_dual_edge == !$past(strap_s[pic_pkg::STRAP_BW]))
    else $error("bus width does not follow strap");
  a_serial_width: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ser_en |=> (o_dual_edge == $past(i_ser_dual_edge)) && (o_scl_oe == $past(i_ser_scl_hold)))
    else $error("width pin still steering in serial mode");
  a_strap_trim: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ser_en ##0 strap_s[pic_pkg::STRAP_SKEW_TRIM_ENABLE] |=> o_skew_en && o_skew_code == $past(strap_code))
    else $error("strap trim code not applied");
  a_trim_default: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !sk_en_d |=> !o_skew_en && o_skew_code == pic_pkg::TRIM_DEFAULT)
    else $error("default trim missing with deskew off");
  a_serial_trim: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ser_en ##0 i_ser_skew_en |=> o_skew_en && o_skew_code == $past(i_ser_skew_code))
    else $error("serial trim not applied");
  a_edge_pd_strap: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ser_en |=> o_rising_primary == $past(strap_s[pic_pkg::STRAP_EDGE])
      && o_power_down == $past(strap_s[pic_pkg::STRAP_PD]))
    else $error("edge or power-down not from straps");
  a_single_pixel: assert property (@(posedge i_input_pixel_clock)
    disable iff (!link_rstn) !l_dual && prim_de |=> o_pix_valid
      && o_pix_data == $past(prim_dat))
    else $error("pixel word not passed");
  a_blank_ctl: assert property (@(posedge i_input_pixel_clock)
    disable iff (!link_rstn) !prim_de |=> !o_pix_valid && o_enc_hsync == $past(prim_hs)
      && o_enc_vsync == $past(prim_vs) && o_enc_ctl[pic_pkg::CTL_W-1] == $past(prim_c3))
    else $error("control symbol not passed in blanking");
  a_dual_pixel: assert property (@(posedge i_input_pixel_clock)
    disable iff (!link_rstn) l_dual && l_rise && rde_q
      |=> o_pix_data == {$past(fdat_q[pic_pkg::HALF_W-1:0]),
      $past(rdat_q[pic_pkg::HALF_W-1:0])})
    else $error("dual-edge pixel assembled wrongly");
  a_ctl_pins: assert property (@(posedge i_input_pixel_clock)
    disable iff (!link_rstn) !l_ctlp |=> o_enc_ctl[pic_pkg::CTL_PIN_W-1:0] == '0)
    else $error("control pins used outside strap mode");

  c_dual_rise: cover property (@(posedge i_input_pixel_clock) disable iff (!link_rstn)
    l_dual && l_rise && rde_q);
  c_dual_fall: cover property (@(posedge i_input_pixel_clock) disable iff (!link_rstn)
    l_dual && !l_rise && fde_q);
  c_blank_to_active: cover property (@(posedge i_input_pixel_clock) disable iff (!link_rstn)
    !o_pix_valid ##1 o_pix_valid);
  c_conflict: cover property (@(posedge i_clk) disable iff (!i_rstn) o_style_conflict);

endmodule

//--- testbench/pic_gfx_model.sv
// graphics controller model: link clock and pixel pins
// assumes the bench loads one pixel per toggle of o_turn
`timescale 1ns/1ps
module pic_gfx_model (
  input wire logic i_dual,
  input wire logic i_rise,
  input wire logic [23:0] i_pix,
  input wire logic i_de,
  input wire logic i_hs,
  input wire logic i_vs,
  output logic o_clk,
  output logic o_turn,
  output logic [23:0] o_data,
  output logic o_de,
  output logic o_hs,
  output logic o_vs
);
  // ---------------------------------------------
  // free-running single-ended clock, the negative input grounded
  // ---------------------------------------------
  logic [23:0] p;
  initial begin
    o_clk = 1'b0;
    o_turn = 1'b0;
    o_data = 24'h0;
    {o_de, o_hs, o_vs} = 3'h0;
    forever begin
      #12;
      p = i_pix;
      {o_de, o_hs, o_vs} = {i_de, i_hs, i_vs};
      o_data = i_dual ? {~o_data[23:12], p[11:0]} : p;
      // the bench reloads its inputs on this toggle, so sample them first
      o_turn = ~o_turn;
      #12;
      o_clk = i_rise;
      #12;
      // past the primary edge every line shows something else, except in dual mode the lower data half, which carries p[23:12]
      {o_de, o_hs, o_vs} = ~{o_de, o_hs, o_vs};
      o_data = i_dual ? {~o_data[23:12], p[23:12]} : ~p;
      #12;
      o_clk = ~i_rise;
    end
  end
endmodule

//--- testbench/tb_top.sv
// bench for the pixel capture front end: strap table, then pixel bursts
// assumes the design's own assertions guard cycle-level timing
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [15:0] cfg = 16'h0;
  logic g_dual = 1'b0, g_rise = 1'b1, g_de = 1'b0, g_hs = 1'b0, g_vs = 1'b0, mon = 1'b0;
  logic [23:0] g_pix = 24'h0;
  wire logic lclk, turn, de, hs, vs;
  wire logic [23:0] data;
  logic scl_o, scl_oe, c_dual, c_rise, c_diff, c_conf, c_sken, c_pd, pv, ehs, evs;
  logic [2:0] c_code, ectl;
  logic [23:0] pix;
  logic [23:0] q[$];
  int n_errors = 0;
  int num_checks = 0;
  // inputs {serial, width, style, edge, lowsw, skew_trim_enable, mf, ser settings}, then expected
  logic [23:0] rows [5] = '{24'h528040, 24'h2f00ae, 24'h75805b, 24'hdfddad, 24'h842640};

  always #50 i_clk = ~i_clk;

  pic_gfx_model u_gfx (.i_dual(g_dual), .i_rise(g_rise), .i_pix(g_pix), .i_de(g_de),
    .i_hs(g_hs), .i_vs(g_vs), .o_clk(lclk), .o_turn(turn), .o_data(data), .o_de(de),
    .o_hs(hs), .o_vs(vs));

  pic_capture u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_input_pixel_clock(lclk),
    .i_data(data), .i_video_active_qualifier(de), .i_hsync(hs), .i_vsync(vs),
    .i_blanking_control_bit3(~g_dual), .i_bus_width_select(cfg[14]),
    .i_clock_style_select(cfg[13]), .i_edge_select(cfg[12]), .i_low_swing_ref(cfg[11]),
    .i_power_down(cfg[8]), .i_skew_trim_enable(cfg[10]), .i_mf_pins(cfg[9:7]),
    .i_serial_port_enable(cfg[15]), .i_ser_dual_edge(cfg[6]),
    .i_ser_rising_primary(cfg[5]), .i_ser_diff_clock(cfg[4]), .i_ser_skew_en(cfg[3]),
    .i_ser_skew_code(cfg[2:0]), .i_ser_power_down(cfg[0]), .i_ser_scl_hold(cfg[1]),
    .o_scl_o(scl_o), .o_scl_oe(scl_oe), .o_dual_edge(c_dual), .o_rising_primary(c_rise),
    .o_diff_clock(c_diff), .o_style_conflict(c_conf), .o_skew_en(c_sken),
    .o_skew_code(c_code), .o_power_down(c_pd), .o_pix_data(pix), .o_pix_valid(pv),
    .o_enc_hsync(ehs), .o_enc_vsync(evs), .o_enc_ctl(ectl));

  // ---------------------------------------------
  // compare, stimulus and closing tasks
  // ---------------------------------------------
  task automatic chk_cfg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic d, input logic h, input logic v, input logic [23:0] p);
    @(turn);
    {g_de, g_hs, g_vs} = {d, h, v};
    g_pix = p;
    if (d) q.push_back(p);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // blanking must leave the pixel word at zero, active words arrive in order
  always @(posedge lclk) begin
    #1;
    if (mon && pv === 1'b1 && q.size() == 0) chk_cfg(8'h1, 8'h0);
    else if (mon && pv === 1'b1) chk_pix(pix, q.pop_front());
    else if (mon) chk_pix(pix, 24'h0);
  end

  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    chk_cfg({c_dual, c_rise, c_diff, c_conf, c_sken, c_code}, 8'h0);
    @(negedge i_clk);
    i_rstn = 1'b1;
    foreach (rows[i]) begin
      @(negedge i_clk);
      cfg = rows[i][23:8];
      repeat (8) @(negedge i_clk);
      chk_cfg({c_dual, c_rise, c_diff, c_conf, c_sken, c_code}, rows[i][7:0]);
      chk_cfg({6'h0, scl_o, scl_oe}, {6'h0, 1'b0, cfg[15] & cfg[1]});
      chk_cfg({7'h0, c_pd}, {7'h0, cfg[15] ? cfg[0] : cfg[8]});
    end
    // differential low-swing clocking in all four width and edge modes
    for (int m = 0; m < 4; m++) begin
      @(negedge i_clk);
      {g_dual, g_rise} = m[1:0];
      cfg = {1'b0, ~m[1], 1'b1, m[0], 1'b1, 1'b0, 3'h1, 7'h0};
      repeat (12) @(negedge i_clk);
      mon = 1'b1;
      repeat (6) send(1'b0, 1'b1, 1'b0, 24'h0);
      chk_cfg({3'h0, ehs, evs, ectl}, {5'h2, ~m[1], 2'h1});
      for (int k = 0; k < 8; k++) send(1'b1, 1'b0, 1'b0, 24'ha5c3f0 ^ {3{8'(k * 37)}});
      repeat (6) send(1'b0, 1'b0, 1'b1, 24'h0);
      chk_cfg({3'h0, ehs, evs, ectl}, {5'h1, ~m[1], 2'h1});
      chk_cfg(8'(q.size()), 8'h0);
      mon = 1'b0;
    end
    // mid-run reset: both domains return to their reset values
    @(negedge i_clk);
    i_rstn = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_cfg({c_dual, c_rise, c_diff, c_conf, c_sken, c_code}, 8'h0);
    chk_cfg({c_pd, scl_oe, pv, ehs, evs, ectl}, 8'h0);
    chk_pix(pix, 24'h0);
    i_rstn = 1'b1;
    repeat (8) @(negedge i_clk);
    conclude();
  end
endmodule
